/* File: design/buck_regs_pkg.sv */
// constants for the step-down and buck-boost control register slice
package buck_regs_pkg;
  localparam logic [7:0] primary_stepdown_addr = 8'h05;
  localparam logic [7:0] secondary_stepdown_addr = 8'h06;
  localparam logic [7:0] buck_boost_addr = 8'h07;
  localparam int enable_bit = 6;
  localparam int force_pwm_bit = 5;
  localparam int bb_force_pwm_bit = 6;
  localparam int bb_enable_bit = 5;
  localparam int vsel_msb = 4;
  localparam int stored_msb = 6;
  localparam int reserved_bit = 7;
  localparam logic [4:0] vsel_external = 5'h00;
  localparam logic [4:0] vsel_zero = 5'h00;
  localparam logic [7:0] read_zero = 8'h00;
endpackage : buck_regs_pkg

/* File: design/reg_decode.sv */
// field unpacking for one converter control register
`timescale 1ns/1ps
`default_nettype none
module reg_decode (
  input wire logic [7:0] value_in,
  input wire logic bb_layout_in,
  output logic enable_field_out,
  output logic pwm_field_out,
  output logic [4:0] vsel_out
);
  always_comb begin
    vsel_out = value_in[buck_regs_pkg::vsel_msb:0];
    if (bb_layout_in) begin
      enable_field_out = value_in[buck_regs_pkg::bb_enable_bit]; // [RULE10]
      pwm_field_out = value_in[buck_regs_pkg::bb_force_pwm_bit]; // [RULE10]
    end else begin
      enable_field_out = value_in[buck_regs_pkg::enable_bit];
      pwm_field_out = value_in[buck_regs_pkg::force_pwm_bit]; // [RULE13]
    end
  end
endmodule : reg_decode
`default_nettype wire

/* File: design/buck_regulator_control_regs.sv */
// control register bank for two step-down converters and the buck-boost
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Function
// [RULE1] primary register at 0x05; enable and pwm reset 0, voltage from factory default
// [RULE2] secondary register: bit 7 reads 0; bits 6..0 read/write
// [RULE3] secondary bit 6 enables; bit 5 zero is auto mode; code 0 external
// [RULE4] secondary codes 1..15 give 1.80..3.20 V, upper-bit codes 3.30 V
// [RULE5] secondary register at 0x06 resets enabled, pwm 0, voltage factory default
// [RULE6] host writes buck-boost voltage before setting its enable bit
// [RULE7] buck-boost held off while its voltage code is zero
// [RULE8] buck-boost register at 0x07 resets enabled, pwm clear
// [RULE9] buck-boost voltage resets to factory default code
// [RULE10] buck-boost: bit 7 reserved 0, bit 6 pwm, bit 5 enable, bits 4..0 voltage
// [RULE11] buck-boost codes 1..31 span 1.80..3.30 V; code 0 disabled
// [RULE12] primary on if bit 6 set, else follows external enable pin
// [RULE13] bit 5 forces pwm, else automatic pwm/pfm selection
module buck_regulator_control_regs #(
  parameter logic [4:0] primary_default_vsel = 5'h01,
  parameter logic [4:0] secondary_default_vsel = 5'h01,
  parameter logic [4:0] bb_default_vsel = 5'h1f
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic primary_stepdown_enable_pin_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  output logic primary_stepdown_on_out,
  output logic primary_stepdown_pwm_out,
  output logic [4:0] primary_stepdown_vsel_out,
  output logic secondary_stepdown_on_out,
  output logic secondary_stepdown_pwm_out,
  output logic [4:0] secondary_stepdown_vsel_out,
  output logic buck_boost_on_out,
  output logic buck_boost_pwm_out,
  output logic [4:0] buck_boost_vsel_out
);
  typedef struct packed {
    logic pin_meta;
    logic pin_sync;
    logic [6:0] primary;
    logic [6:0] secondary;
    logic [6:0] bb;
    logic [7:0] rdata;
    logic p_on;
    logic p_pwm;
    logic [4:0] p_vsel;
    logic s_on;
    logic s_pwm;
    logic [4:0] s_vsel;
    logic b_on;
    logic b_pwm;
    logic [4:0] b_vsel;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic p_en;
  logic p_pwm;
  logic s_en;
  logic s_pwm;
  logic b_en;
  logic b_pwm;
  logic [4:0] p_v;
  logic [4:0] s_v;
  logic [4:0] b_v;

  ////////////////////////////////////////////////////////////////////////////////
  reg_decode u_p (.value_in({1'b0, state_reg.primary}), .bb_layout_in(1'b0),
    .enable_field_out(p_en), .pwm_field_out(p_pwm), .vsel_out(p_v));
  reg_decode u_s (.value_in({1'b0, state_reg.secondary}), .bb_layout_in(1'b0),
    .enable_field_out(s_en), .pwm_field_out(s_pwm), .vsel_out(s_v));
  reg_decode u_b (.value_in({1'b0, state_reg.bb}), .bb_layout_in(1'b1),
    .enable_field_out(b_en), .pwm_field_out(b_pwm), .vsel_out(b_v));

  ////////////////////////////////////////////////////////////////////////////////
  // overlapping fields would let one written bit steer two controls
  if (buck_regs_pkg::bb_enable_bit == buck_regs_pkg::bb_force_pwm_bit
      || buck_regs_pkg::vsel_msb >= buck_regs_pkg::force_pwm_bit) begin : g_layout_check
    $error("control bits overlap in the register layout");
  end
  // a zero default would keep the buck-boost off after power-up
  if (bb_default_vsel == buck_regs_pkg::vsel_zero) begin : g_bb_default_check
    $error("buck-boost default code must not be zero");
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    state_next.pin_meta = primary_stepdown_enable_pin_in;
    state_next.pin_sync = state_reg.pin_meta;
    // bit 7 is not stored, so it always reads back 0
    if (reg_write_in && reg_addr_in == buck_regs_pkg::primary_stepdown_addr) begin
      state_next.primary = reg_wdata_in[buck_regs_pkg::stored_msb:0];
    end else if (reg_write_in && reg_addr_in == buck_regs_pkg::secondary_stepdown_addr) begin
      state_next.secondary = reg_wdata_in[buck_regs_pkg::stored_msb:0]; // [RULE2]
    end else if (reg_write_in && reg_addr_in == buck_regs_pkg::buck_boost_addr) begin
      state_next.bb = reg_wdata_in[buck_regs_pkg::stored_msb:0]; // [RULE10]
    end
    if (reg_read_in && reg_addr_in == buck_regs_pkg::primary_stepdown_addr) begin
      state_next.rdata = {1'b0, state_reg.primary};
    end else if (reg_read_in && reg_addr_in == buck_regs_pkg::secondary_stepdown_addr) begin
      state_next.rdata = {1'b0, state_reg.secondary}; // [RULE2]
    end else if (reg_read_in && reg_addr_in == buck_regs_pkg::buck_boost_addr) begin
      state_next.rdata = {1'b0, state_reg.bb};
    end else if (reg_read_in) begin
      state_next.rdata = buck_regs_pkg::read_zero;
    end
    state_next.p_on = p_en | state_reg.pin_sync; // [RULE12]
    state_next.p_pwm = p_pwm; // [RULE13]
    state_next.p_vsel = p_v;
    state_next.s_on = s_en; // [RULE3]
    state_next.s_pwm = s_pwm; // [RULE13]
    // code 0 means external control; decoding to volts lives in the analog stage
    state_next.s_vsel = s_v; // [RULE4]
    // a zero code wins over the enable bit, so a careless host cannot start it at 0 V
    state_next.b_on = b_en && (b_v != buck_regs_pkg::vsel_zero); // [RULE7]
    state_next.b_pwm = b_pwm;
    state_next.b_vsel = b_v; // [RULE11]
    if (!rst_n_in) begin
      state_next = '0;
      state_next.primary[buck_regs_pkg::vsel_msb:0] = primary_default_vsel; // [RULE1]
      state_next.secondary[buck_regs_pkg::vsel_msb:0] = secondary_default_vsel; // [RULE5]
      state_next.secondary[buck_regs_pkg::enable_bit] = 1'b1; // [RULE5]
      state_next.bb[buck_regs_pkg::vsel_msb:0] = bb_default_vsel; // [RULE9]
      state_next.bb[buck_regs_pkg::bb_enable_bit] = 1'b1; // [RULE8]
    end
  end

  always_ff @(posedge clk_in) begin
    state_reg <= state_next;
  end

  assign reg_rdata_out = state_reg.rdata;
  assign primary_stepdown_on_out = state_reg.p_on;
  assign primary_stepdown_pwm_out = state_reg.p_pwm;
  assign primary_stepdown_vsel_out = state_reg.p_vsel;
  assign secondary_stepdown_on_out = state_reg.s_on;
  assign secondary_stepdown_pwm_out = state_reg.s_pwm;
  assign secondary_stepdown_vsel_out = state_reg.s_vsel;
  assign buck_boost_on_out = state_reg.b_on;
  assign buck_boost_pwm_out = state_reg.b_pwm;
  assign buck_boost_vsel_out = state_reg.b_vsel;

  ////////////////////////////////////////////////////////////////////////////////
  a_bb_zero_off: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE7]
    $past(rst_n_in) && state_reg.bb[buck_regs_pkg::vsel_msb:0] == buck_regs_pkg::vsel_zero |=> !buck_boost_on_out)
    else $error("buck-boost on with zero code");
  a_bb_on_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE10]
    $past(rst_n_in) && state_reg.bb[buck_regs_pkg::bb_enable_bit]
    && state_reg.bb[buck_regs_pkg::vsel_msb:0] != buck_regs_pkg::vsel_zero |=> buck_boost_on_out)
    else $error("buck-boost not on");
  a_p_pin_enable: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE12]
    $past(rst_n_in) && state_reg.pin_sync |=> primary_stepdown_on_out)
    else $error("primary ignores pin");
  a_p_off: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE12]
    $past(rst_n_in) && !state_reg.pin_sync && !state_reg.primary[buck_regs_pkg::enable_bit]
    |=> !primary_stepdown_on_out)
    else $error("primary on while disabled");
  a_s_write_rd: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE2]
    reg_write_in && reg_addr_in == buck_regs_pkg::secondary_stepdown_addr
    ##1 reg_read_in && reg_addr_in == buck_regs_pkg::secondary_stepdown_addr && !reg_write_in
    |=> reg_rdata_out == {1'b0, $past(reg_wdata_in[buck_regs_pkg::stored_msb:0], 2)})
    else $error("secondary readback wrong");
  a_rd_top_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE10]
    reg_read_in |=> reg_rdata_out[buck_regs_pkg::reserved_bit] == 1'b0)
    else $error("reserved bit reads one");
  a_reset_vals: assert property (@(posedge clk_in) // [RULE5]
    !rst_n_in |=> state_reg.secondary[buck_regs_pkg::enable_bit]
    && !state_reg.secondary[buck_regs_pkg::force_pwm_bit]
    && state_reg.bb[buck_regs_pkg::bb_enable_bit] && !state_reg.bb[buck_regs_pkg::bb_force_pwm_bit]
    && !state_reg.primary[buck_regs_pkg::enable_bit] && !state_reg.primary[buck_regs_pkg::force_pwm_bit])
    else $error("reset values wrong");
  a_s_pwm: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE13]
    $past(rst_n_in) |=> secondary_stepdown_pwm_out == $past(state_reg.secondary[buck_regs_pkg::force_pwm_bit]))
    else $error("secondary pwm wrong");

  a_s_on_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE3]
    $past(rst_n_in) |=> secondary_stepdown_on_out == $past(state_reg.secondary[buck_regs_pkg::enable_bit]))
    else $error("secondary enable wrong");

  a_s_off: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE3]
    $past(rst_n_in) && !state_reg.secondary[buck_regs_pkg::enable_bit] |=> !secondary_stepdown_on_out)
    else $error("secondary on while disabled");

  // the code is passed on raw; volts are chosen in the analog stage
  a_s_vsel_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE4]
    $past(rst_n_in) |=> secondary_stepdown_vsel_out == $past(state_reg.secondary[buck_regs_pkg::vsel_msb:0]))
    else $error("secondary code wrong");

  a_bb_pwm_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE10]
    $past(rst_n_in) |=> buck_boost_pwm_out == $past(state_reg.bb[buck_regs_pkg::bb_force_pwm_bit]))
    else $error("buck-boost pwm wrong");

  a_bb_vsel_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE11]
    $past(rst_n_in) |=> buck_boost_vsel_out == $past(state_reg.bb[buck_regs_pkg::vsel_msb:0]))
    else $error("buck-boost code wrong");

  a_p_pwm_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE13]
    $past(rst_n_in) |=> primary_stepdown_pwm_out == $past(state_reg.primary[buck_regs_pkg::force_pwm_bit]))
    else $error("primary pwm wrong");

  a_p_vsel_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE1]
    $past(rst_n_in) |=> primary_stepdown_vsel_out == $past(state_reg.primary[buck_regs_pkg::vsel_msb:0]))
    else $error("primary code wrong");

  a_p_reg_enable: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE12]
    $past(rst_n_in) && state_reg.primary[buck_regs_pkg::enable_bit] |=> primary_stepdown_on_out)
    else $error("primary ignores enable bit");

  a_unmapped_rd: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE2]
    reg_read_in && reg_addr_in != buck_regs_pkg::primary_stepdown_addr
    && reg_addr_in != buck_regs_pkg::secondary_stepdown_addr && reg_addr_in != buck_regs_pkg::buck_boost_addr
    |=> reg_rdata_out == buck_regs_pkg::read_zero)
    else $error("unmapped read not zero");

  // read data must stand until the next read so a slow host can still take it
  a_rdata_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE2]
    $past(rst_n_in) && !reg_read_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");

  a_reset_codes: assert property (@(posedge clk_in) // [RULE9]
    !rst_n_in |=> state_reg.primary[buck_regs_pkg::vsel_msb:0] == primary_default_vsel
    && state_reg.secondary[buck_regs_pkg::vsel_msb:0] == secondary_default_vsel
    && state_reg.bb[buck_regs_pkg::vsel_msb:0] == bb_default_vsel)
    else $error("reset codes wrong");
endmodule : buck_regulator_control_regs
`default_nettype wire

/* File: tb/host_model.sv */
// host stand-in that issues single-byte register accesses on the strobe bus
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_in,
  output logic [7:0] addr_out,
  output logic write_out,
  output logic [7:0] wdata_out,
  output logic read_out
);
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    write_out = 1'b0;
    read_out = 1'b0;
  end
  // released lines flip so a stale value can never look valid
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    write_out <= w;
    read_out <= ~w;
    @(posedge clk_in);
    write_out <= 1'b0;
    read_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask : acc
  // write then read back at once, the tightest spacing the bus allows
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    write_out <= 1'b1;
    @(posedge clk_in);
    write_out <= 1'b0;
    read_out <= 1'b1;
    @(posedge clk_in);
    read_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask : wr_rd
endmodule : host_model
`default_nettype wire

/* File: tb/buck_regulator_control_regs_test.sv */
// testbench for the converter control register slice
`timescale 1ns/1ps
`default_nettype none
module buck_regulator_control_regs_test;
  logic clk_in = 1'b0, rst_n_in = 1'b0, pin = 1'b0, rd_d = 1'b0;
  logic [7:0] addr, wdata, rdata, d;
  logic write, read, p_on, p_pwm, s_on, s_pwm, b_on, b_pwm;
  logic [4:0] p_v, s_v, b_v;
  int err_total = 0, checks = 0, seed = 32'h54dc, k;
  logic [7:0] exp_q[$];
  initial forever #4 clk_in = ~clk_in;
  host_model i_host (.clk_in(clk_in), .addr_out(addr), .write_out(write), .wdata_out(wdata), .read_out(read));
  buck_regulator_control_regs #(.primary_default_vsel(5'h03), .secondary_default_vsel(5'h0a),
    .bb_default_vsel(5'h16)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .primary_stepdown_enable_pin_in(pin), .reg_addr_in(addr), .reg_write_in(write), .reg_wdata_in(wdata),
    .reg_read_in(read), .reg_rdata_out(rdata), .primary_stepdown_on_out(p_on), .primary_stepdown_pwm_out(p_pwm),
    .primary_stepdown_vsel_out(p_v), .secondary_stepdown_on_out(s_on), .secondary_stepdown_pwm_out(s_pwm),
    .secondary_stepdown_vsel_out(s_v), .buck_boost_on_out(b_on), .buck_boost_pwm_out(b_pwm),
    .buck_boost_vsel_out(b_v));
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.acc(a, 8'h00, 1'b0);
  endtask : rd
  task automatic settle();
    repeat (2) @(posedge clk_in);
    #1;
  endtask : settle
  // read data is registered, so the note is due one edge after the strobe
  always @(posedge clk_in) begin
    if (rd_d && exp_q.size() > 0) check("rdata", rdata, exp_q.pop_front());
    rd_d <= read;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    settle();
    check("p_out", {p_on, p_pwm, p_v}, 7'h03);
    check("s_out", {s_on, s_pwm, s_v}, 7'h4a);
    check("b_out", {b_on, b_pwm, b_v}, 7'h56);
    rd(8'h05, 8'h03);
    rd(8'h06, 8'h4a);
    rd(8'h07, 8'h36);
    i_host.acc(8'h06, 8'ha5, 1'b1);
    settle();
    check("s_out", {s_on, s_pwm, s_v}, 7'h25);
    rd(8'h06, 8'h25);
    // back-to-back write and read: the read must see the new value
    exp_q.push_back(8'h5c);
    i_host.wr_rd(8'h06, 8'hdc);
    settle();
    check("s_out", {s_on, s_pwm, s_v}, 7'h5c);
    i_host.acc(8'h07, 8'h20, 1'b1);
    settle();
    check("b_on", b_on, 1'b0);
    i_host.acc(8'h07, 8'h0b, 1'b1);
    i_host.acc(8'h07, 8'h6b, 1'b1);
    settle();
    check("b_out", {b_on, b_pwm, b_v}, 7'h6b);
    i_host.acc(8'h05, 8'h31, 1'b1);
    settle();
    check("p_out", {p_on, p_pwm, p_v}, 7'h31);
    @(posedge clk_in);
    pin <= 1'b1;
    for (k = 0; k < 8 && p_on !== 1'b1; k++) @(posedge clk_in);
    check("p_on", p_on, 1'b1);
    i_host.acc(8'h09, 8'h7f, 1'b1);
    rd(8'h09, 8'h00);
    for (int i = 0; i < 12; i++) begin
      d = $random(seed);
      k = $unsigned($random(seed)) % 3;
      i_host.acc(8'h05 + k[7:0], d, 1'b1);
      rd(8'h05 + k[7:0], d & 8'h7f);
      #1;
      if (k == 2) check("b_on", b_on, d[5] && d[4:0] != 5'h00);
    end
    // second reset in mid-run must bring back the power-up values
    @(posedge clk_in);
    pin <= 1'b0;
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    settle();
    check("p_out", {p_on, p_pwm, p_v}, 7'h03);
    check("s_out", {s_on, s_pwm, s_v}, 7'h4a);
    check("b_out", {b_on, b_pwm, b_v}, 7'h56);
    rd(8'h07, 8'h36);
    settle();
    final_report();
  end
endmodule : buck_regulator_control_regs_test
`default_nettype wire
